// >>> hw/dcs_regs.svh
// Register offsets, field positions, reset values and timing figures of the sync control bank
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// ==========================================================
// Register byte offsets
`define DCS_OFS_TDIFF_DEPTH   12'h934
`define DCS_OFS_SPEED_DEPTH   12'h935
`define DCS_OFS_OWNERSHIP     12'h980
`define DCS_OFS_ACTIVATION    12'h981
`define DCS_OFS_PULSE_LEN_LO  12'h982
`define DCS_OFS_PULSE_LEN_HI  12'h983
`define DCS_OFS_STATUS_A      12'h98E
`define DCS_OFS_STATUS_B      12'h98F

// ==========================================================
// Reset values
`define DCS_RST_TDIFF_DEPTH   4'h4
`define DCS_RST_SPEED_DEPTH   4'hC
`define DCS_RST_PULSE_LEN     16'h0000

// ==========================================================
// Ownership register bit positions
`define DCS_OWN_SYNC          0
`define DCS_OWN_LATCH0        4
`define DCS_OWN_LATCH1        5

// ==========================================================
// Activation register bit positions
`define DCS_ACT_UNIT          0
`define DCS_ACT_GEN_A         1
`define DCS_ACT_GEN_B         2
`define DCS_ACT_AUTO          3
`define DCS_ACT_EXTEND        4
`define DCS_ACT_PLAUS         5
`define DCS_ACT_NEAR          6
`define DCS_ACT_DEBUG         7

// ==========================================================
// Pulse timing: length unit and clock period, both in ns
`define DCS_UNIT_NS           21'h0000A
`define DCS_CYCLE_NS          21'h00019

`endif

// >>> hw/dcs_pkg.sv
// Types shared by the sync control bank modules
package dcs_pkg;

   // ==========================================================
   // Pulse generator state
   typedef struct packed {
      logic        pulseOut;   // Sync output level
      logic        ackMode;    // Pulse held until status read
      logic [20:0] remNs;      // Remaining pulse time in ns
   } dcs_pulse_state_t;

   // ==========================================================
   // Latch interrupt router state
   typedef struct packed {
      logic irqFieldbus;       // Interrupt toward fieldbus side
      logic irqHost;           // Interrupt toward host interface
   } dcs_route_state_t;

   // ==========================================================
   // Register bank state
   typedef struct packed {
      logic [3:0]  timeDiffDepth;    // System time deviation filter depth
      logic [3:0]  speedDepth;       // Clock period filter depth
      logic        latch0Own;        // Stored latch unit 0 ownership
      logic        latch1Own;        // Latch unit 1 ownership
      logic        syncOwn;          // Sync unit ownership
      logic        latch0Eff;        // Effective latch unit 0 ownership
      logic [7:0]  activation;       // Activation register
      logic [15:0] pulseLen;         // Pulse length in 10 ns units
      logic        timeDiffReset;    // Pulse: clear time difference
      logic        speedFilterReset; // Pulse: clear speed filter
      logic [7:0]  fbRdata;          // Fieldbus read data
      logic [7:0]  hiRdata;          // Host read data
   } dcs_bank_state_t;

endpackage

// >>> hw/dcs_pulse_gen.sv
// Sync output pulse timer with timed and acknowledge modes
`include "dcs_regs.svh"
module dcs_pulse_gen
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Control
   input  wire logic        trigger,
   input  wire logic [15:0] pulseLen,
   input  wire logic        ackClear,
   // Output
   output logic             pulseOut
);
   import dcs_pkg::*;

   dcs_pulse_state_t s;        // Current state
   dcs_pulse_state_t next_s;   // Next state

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      if (trigger) begin
         // Start, or restart, a pulse
         next_s.pulseOut = 1'b1;
         next_s.ackMode  = (pulseLen == 16'h0000);
         next_s.remNs    = 21'({5'h00, pulseLen} * `DCS_UNIT_NS);
      end else if (s.pulseOut && s.ackMode) begin
         // Held until the status register is read
         if (ackClear) begin
            next_s.pulseOut = 1'b0;
            next_s.ackMode  = 1'b0;
         end
      end else if (s.pulseOut) begin
         // Count down whole clock periods; rounds up to full cycles
         if (s.remNs <= `DCS_CYCLE_NS) begin
            next_s.pulseOut = 1'b0;
            next_s.remNs    = 21'h00000;
         end else begin
            next_s.remNs = s.remNs - `DCS_CYCLE_NS;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pulseOut = s.pulseOut;

endmodule

// >>> hw/dcs_latch_route.sv
// Routes one latch unit's interrupt to its owning interface
module dcs_latch_route
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Event and owner
   input  wire logic latchEvent,
   input  wire logic hostOwned,
   // Routed interrupts
   output logic      irqFieldbus,
   output logic      irqHost
);
   import dcs_pkg::*;

   dcs_route_state_t s;        // Current state
   dcs_route_state_t next_s;   // Next state

   // ==========================================================
   // Steer the event by ownership
   always_comb begin
      next_s.irqFieldbus = latchEvent && !hostOwned;
      next_s.irqHost     = latchEvent && hostOwned;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign irqFieldbus = s.irqFieldbus;
   assign irqHost     = s.irqHost;

endmodule

// >>> hw/dcs_sync_ctrl.sv
// Distributed clock sync activation and ownership register bank
`include "dcs_regs.svh"
// ==========================================================
// Overview of operation
// - 4-bit time filter depth, reset 4, write clears
// - 4-bit speed filter depth, reset 12, write resets
// - Bit 5 gives latch unit 1 owner
// - Latch interrupts follow their unit's owner
// - Bit 4 latch 0 owner, forced host while host runs system time
// - Bit 0 selects sync unit owner
// - Activation writes only from sync owner
// - Bit 7 fires debug pulse on enabled outputs
// - Bit 6 selects near future window
// - Bit 5 enables immediate start when outside
// - Bit 4 extends 32-bit start time
// - Bit 3 auto-activates on start time write
// - Bits 2 and 1 enable sync outputs
// - Pulse length counted in 10 ns units
// - Zero length selects acknowledge mode
// - Pulse length read-only, loaded from EEPROM
// - Wide registers little-endian by byte address
// - Host status read clears acknowledged sync
module dcs_sync_ctrl
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Fieldbus side register port
   input  wire logic [11:0] fbAddr,
   input  wire logic        fbWrite,
   input  wire logic        fbRead,
   input  wire logic [7:0]  fbWdata,
   output logic      [7:0]  fbRdata,
   // Host interface register port
   input  wire logic [11:0] hiAddr,
   input  wire logic        hiWrite,
   input  wire logic        hiRead,
   input  wire logic [7:0]  hiWdata,
   output logic      [7:0]  hiRdata,
   // Configuration load and system time mode
   input  wire logic        eepromLoad,
   input  wire logic [15:0] eepromPulseLen,
   input  wire logic        sysTimeHostCtrl,
   // Cyclic unit and latch unit events
   input  wire logic        startTimeWritten,
   input  wire logic        syncStartA,
   input  wire logic        syncStartB,
   input  wire logic        latchEvent0,
   input  wire logic        latchEvent1,
   // Filter control
   output logic      [3:0]  timeDiffDepth,
   output logic      [3:0]  speedDepth,
   output logic             timeDiffReset,
   output logic             speedFilterReset,
   // Ownership
   output logic             latch0Host,
   output logic             latch1Host,
   output logic             syncHostOwned,
   output logic      [1:0]  latchIrqFieldbus,
   output logic      [1:0]  latchIrqHost,
   // Activation controls
   output logic             syncUnitActive,
   output logic             nearFutureShort,
   output logic             plausCheckEn,
   output logic             startTimeExtend,
   output logic             autoActivate,
   // Sync outputs
   output logic             syncOutA,
   output logic             syncOutB
);
   import dcs_pkg::*;

   dcs_bank_state_t s;        // Current state
   dcs_bank_state_t next_s;   // Next state

   logic fbWrTdiff;           // Fieldbus write to time filter depth
   logic fbWrSpeed;           // Fieldbus write to speed filter depth
   logic fbWrOwn;             // Fieldbus write to ownership
   logic actWrite;            // Accepted activation write
   logic [7:0] actWdata;      // Data of accepted activation write
   logic debugFire;           // Debug pulse request
   logic trigA;               // Pulse start on output A
   logic trigB;               // Pulse start on output B
   logic ackClrA;             // Host status read of output A
   logic ackClrB;             // Host status read of output B

   // ==========================================================
   // Read decode shared by both ports
   function automatic logic [7:0] readReg(input logic [11:0] addr,
                                          input dcs_bank_state_t st,
                                          input logic outA,
                                          input logic outB);
      logic [7:0] val;
      val = 8'h00;
      case (addr)
         `DCS_OFS_TDIFF_DEPTH:  val = {4'h0, st.timeDiffDepth};
         `DCS_OFS_SPEED_DEPTH:  val = {4'h0, st.speedDepth};
         // Reserved bits return zero
         `DCS_OFS_OWNERSHIP:    val = {2'b00, st.latch1Own, st.latch0Eff,
                                       3'b000, st.syncOwn};
         `DCS_OFS_ACTIVATION:   val = st.activation;
         // Low byte at the lower address
         `DCS_OFS_PULSE_LEN_LO: val = st.pulseLen[7:0];
         `DCS_OFS_PULSE_LEN_HI: val = st.pulseLen[15:8];
         `DCS_OFS_STATUS_A:     val = {7'h00, outA};
         `DCS_OFS_STATUS_B:     val = {7'h00, outB};
         default:               val = 8'h00;
      endcase
      return val;
   endfunction

   // ==========================================================
   // Write qualification
   always_comb begin
      // Filter and ownership writes only from the fieldbus side
      fbWrTdiff = fbWrite && (fbAddr == `DCS_OFS_TDIFF_DEPTH);
      fbWrSpeed = fbWrite && (fbAddr == `DCS_OFS_SPEED_DEPTH);
      fbWrOwn   = fbWrite && (fbAddr == `DCS_OFS_OWNERSHIP);
      // Activation writable only by the current sync unit owner
      if (s.syncOwn) begin
         actWrite = hiWrite && (hiAddr == `DCS_OFS_ACTIVATION);
         actWdata = hiWdata;
      end else begin
         actWrite = fbWrite && (fbAddr == `DCS_OFS_ACTIVATION);
         actWdata = fbWdata;
      end
      // Debug pulse on each output enabled by the new value
      debugFire = actWrite && actWdata[`DCS_ACT_DEBUG];
      trigA = (debugFire && actWdata[`DCS_ACT_GEN_A]) ||
              (syncStartA && s.activation[`DCS_ACT_UNIT] &&
               s.activation[`DCS_ACT_GEN_A]);
      trigB = (debugFire && actWdata[`DCS_ACT_GEN_B]) ||
              (syncStartB && s.activation[`DCS_ACT_UNIT] &&
               s.activation[`DCS_ACT_GEN_B]);
      // Status reads from the host clear held outputs
      ackClrA = hiRead && (hiAddr == `DCS_OFS_STATUS_A);
      ackClrB = hiRead && (hiAddr == `DCS_OFS_STATUS_B);
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      // Filter depths; any fieldbus write also pulses the matching reset
      next_s.timeDiffReset    = fbWrTdiff;
      next_s.speedFilterReset = fbWrSpeed;
      if (fbWrTdiff) begin
         next_s.timeDiffDepth = fbWdata[3:0];
      end
      if (fbWrSpeed) begin
         next_s.speedDepth = fbWdata[3:0];
      end
      // Ownership bits
      if (fbWrOwn) begin
         next_s.syncOwn   = fbWdata[`DCS_OWN_SYNC];
         next_s.latch0Own = fbWdata[`DCS_OWN_LATCH0];
         next_s.latch1Own = fbWdata[`DCS_OWN_LATCH1];
      end
      // Latch unit 0 forced to host while host runs system time
      next_s.latch0Eff = next_s.latch0Own || sysTimeHostCtrl;
      // Activation register
      if (actWrite) begin
         next_s.activation = actWdata;
      end
      // Auto-activation wins over a simultaneous clearing write
      if (startTimeWritten && s.activation[`DCS_ACT_AUTO]) begin
         next_s.activation[`DCS_ACT_UNIT] = 1'b1;
      end
      // Pulse length only from the configuration load
      if (eepromLoad) begin
         next_s.pulseLen = eepromPulseLen;
      end
      // Read data captured on each read strobe
      if (fbRead) begin
         next_s.fbRdata = readReg(fbAddr, s, syncOutA, syncOutB);
      end
      if (hiRead) begin
         next_s.hiRdata = readReg(hiAddr, s, syncOutA, syncOutB);
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s               <= '0;
         s.timeDiffDepth <= `DCS_RST_TDIFF_DEPTH;
         s.speedDepth    <= `DCS_RST_SPEED_DEPTH;
         s.pulseLen      <= `DCS_RST_PULSE_LEN;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Sync output timers
   dcs_pulse_gen u_pulse_a (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .trigger  (trigA),
      .pulseLen (s.pulseLen),
      .ackClear (ackClrA),
      .pulseOut (syncOutA)
   );

   dcs_pulse_gen u_pulse_b (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .trigger  (trigB),
      .pulseLen (s.pulseLen),
      .ackClear (ackClrB),
      .pulseOut (syncOutB)
   );

   // ==========================================================
   // Latch interrupt routers
   dcs_latch_route u_route_0 (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .latchEvent  (latchEvent0),
      .hostOwned   (s.latch0Eff),
      .irqFieldbus (latchIrqFieldbus[0]),
      .irqHost     (latchIrqHost[0])
   );

   dcs_latch_route u_route_1 (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .latchEvent  (latchEvent1),
      .hostOwned   (s.latch1Own),
      .irqFieldbus (latchIrqFieldbus[1]),
      .irqHost     (latchIrqHost[1])
   );

   // ==========================================================
   // Outputs straight from the state register
   assign fbRdata          = s.fbRdata;
   assign hiRdata          = s.hiRdata;
   assign timeDiffDepth    = s.timeDiffDepth;
   assign speedDepth       = s.speedDepth;
   assign timeDiffReset    = s.timeDiffReset;
   assign speedFilterReset = s.speedFilterReset;
   assign latch0Host       = s.latch0Eff;
   assign latch1Host       = s.latch1Own;
   assign syncHostOwned    = s.syncOwn;
   assign syncUnitActive   = s.activation[`DCS_ACT_UNIT];
   assign nearFutureShort  = s.activation[`DCS_ACT_NEAR];
   assign plausCheckEn     = s.activation[`DCS_ACT_PLAUS];
   assign startTimeExtend  = s.activation[`DCS_ACT_EXTEND];
   assign autoActivate     = s.activation[`DCS_ACT_AUTO];

endmodule

// >>> bench/dcs_event_src.sv
// Event source model standing in for the cyclic generator and latch units
module dcs_event_src (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Requests from the bench
   input  wire logic [4:0] evReq,
   input  wire logic       slow,
   // Event pulses toward the bank
   output logic            startTimeWritten,
   output logic            syncStartA,
   output logic            syncStartB,
   output logic            latchEvent0,
   output logic            latchEvent1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] stage1;  // One cycle of extra delay
   logic [4:0] evOut;   // Registered event pulses
   // ==========================================================
   // One-cycle pulses, prompt or one cycle late
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         stage1 <= 5'h00;
         evOut  <= 5'h00;
      end else begin
         stage1 <= evReq;
         evOut  <= slow ? stage1 : evReq;  // Start time event only on request
      end
   end
   assign {latchEvent1, latchEvent0, syncStartB, syncStartA, startTimeWritten} = evOut;
endmodule

// >>> bench/dcs_sync_ctrl_checker.sv
// Concurrent checks on the sync control bank ports
`include "dcs_regs.svh"
module dcs_sync_ctrl_checker (
   // Clock, reset and register ports
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [11:0] fbAddr,
   input wire logic        fbWrite,
   input wire logic [7:0]  fbWdata,
   input wire logic [11:0] hiAddr,
   input wire logic        hiWrite,
   input wire logic        hiRead,
   input wire logic [7:0]  hiRdata,
   // Events and outputs
   input wire logic        sysTimeHostCtrl,
   input wire logic        startTimeWritten,
   input wire logic        latchEvent1,
   input wire logic [3:0]  timeDiffDepth,
   input wire logic [3:0]  speedDepth,
   input wire logic        timeDiffReset,
   input wire logic        speedFilterReset,
   input wire logic        latch0Host,
   input wire logic        latch1Host,
   input wire logic        syncHostOwned,
   input wire logic [1:0]  latchIrqFieldbus,
   input wire logic [1:0]  latchIrqHost,
   input wire logic        syncUnitActive,
   input wire logic        autoActivate,
   input wire logic        syncOutA
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Assertions
   chk_tdiff_write: assert property (fbWrite && fbAddr == `DCS_OFS_TDIFF_DEPTH |=>
      timeDiffReset && timeDiffDepth == $past(fbWdata[3:0])) else $error("depth write wrong");
   chk_speed_write: assert property (fbWrite && fbAddr == `DCS_OFS_SPEED_DEPTH |=>
      speedFilterReset && speedDepth == $past(fbWdata[3:0])) else $error("speed write wrong");
   chk_host_nowrite: assert property (hiWrite && !fbWrite && hiAddr == `DCS_OFS_TDIFF_DEPTH
      |=> !timeDiffReset && $stable(timeDiffDepth)) else $error("host depth write taken");
   chk_latch0_forced: assert property (sysTimeHostCtrl [*2] |-> latch0Host)
      else $error("latch 0 not forced to host");
   chk_latch_route: assert property (latchEvent1 |=> latchIrqHost[1] == $past(latch1Host)
      && latchIrqFieldbus[1] != $past(latch1Host)) else $error("latch irq misrouted");
   chk_act_owner: assert property (hiWrite && hiAddr == `DCS_OFS_ACTIVATION && !syncHostOwned
      && !fbWrite && !startTimeWritten |=> $stable({syncUnitActive, autoActivate}))
      else $error("activation written by non-owner");
   chk_auto_act: assert property (startTimeWritten && autoActivate |=> syncUnitActive)
      else $error("auto activation missing");
   chk_status_read: assert property (hiRead && hiAddr == `DCS_OFS_STATUS_A |=>
      hiRdata == {7'h00, $past(syncOutA)}) else $error("status read wrong");
   chk_debug_pulse: assert property (fbWrite && fbAddr == `DCS_OFS_ACTIVATION && !syncHostOwned
      && fbWdata[7] && fbWdata[1] |=> syncOutA) else $error("debug pulse missing");
   // ==========================================================
   // Coverage of main scenarios
   cov_debug: cover property (fbWrite && fbAddr == `DCS_OFS_ACTIVATION && fbWdata[7]);
   cov_ack: cover property (hiRead && hiAddr == `DCS_OFS_STATUS_A && syncOutA);
   cov_auto: cover property (startTimeWritten && autoActivate);
endmodule
bind dcs_sync_ctrl dcs_sync_ctrl_checker i_chk (.clk_sys, .rst_b, .fbAddr, .fbWrite, .fbWdata,
   .hiAddr, .hiWrite, .hiRead, .hiRdata, .sysTimeHostCtrl, .startTimeWritten, .latchEvent1,
   .timeDiffDepth, .speedDepth, .timeDiffReset, .speedFilterReset, .latch0Host, .latch1Host,
   .syncHostOwned, .latchIrqFieldbus, .latchIrqHost, .syncUnitActive, .autoActivate, .syncOutA);

// >>> bench/tb_top.sv
// Self-checking bench for the sync control bank
`include "dcs_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst_b, fbWrite, fbRead, hiWrite, hiRead, eepromLoad, sysTimeHostCtrl;
   logic [11:0] fbAddr, hiAddr;
   logic [7:0]  fbWdata, hiWdata, fbRdata, hiRdata, q, d;
   logic [15:0] eepromPulseLen;
   logic [4:0]  evReq;
   logic        slow, startTimeWritten, syncStartA, syncStartB, latchEvent0, latchEvent1;
   logic [3:0]  timeDiffDepth, speedDepth;
   logic        timeDiffReset, speedFilterReset, latch0Host, latch1Host, syncHostOwned;
   logic [1:0]  latchIrqFieldbus, latchIrqHost;
   logic        syncUnitActive, nearFutureShort, plausCheckEn, startTimeExtend, autoActivate;
   logic        syncOutA, syncOutB;
   int          n_mismatch, checks, seed, mTd, mSp, mOwn, mAct, mLen, w;
   int          lens [4] = '{1, 5, 'h100, 0};
   logic [11:0] regList [7] = '{`DCS_OFS_TDIFF_DEPTH, `DCS_OFS_SPEED_DEPTH, `DCS_OFS_OWNERSHIP,
      `DCS_OFS_ACTIVATION, `DCS_OFS_PULSE_LEN_LO, `DCS_OFS_PULSE_LEN_HI, 12'h9A0};
   dcs_sync_ctrl i_dcs_sync_ctrl (.clk_sys, .rst_b, .fbAddr, .fbWrite, .fbRead, .fbWdata,
      .fbRdata, .hiAddr, .hiWrite, .hiRead, .hiWdata, .hiRdata, .eepromLoad, .eepromPulseLen,
      .sysTimeHostCtrl, .startTimeWritten, .syncStartA, .syncStartB, .latchEvent0, .latchEvent1,
      .timeDiffDepth, .speedDepth, .timeDiffReset, .speedFilterReset, .latch0Host, .latch1Host,
      .syncHostOwned, .latchIrqFieldbus, .latchIrqHost, .syncUnitActive, .nearFutureShort,
      .plausCheckEn, .startTimeExtend, .autoActivate, .syncOutA, .syncOutB);
   dcs_event_src i_dcs_event_src (.clk_sys, .rst_b, .evReq, .slow, .startTimeWritten,
      .syncStartA, .syncStartB, .latchEvent0, .latchEvent1);
   // ==========================================================
   // Clock and hang watchdog
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      #500us;
      n_mismatch++;
      end_sim();
   end
   // ==========================================================
   // Shared tasks
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One register access, strobe held for one edge
   task automatic regAcc(input bit h, input bit wrt, input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      if (h) begin
         hiAddr  <= a;
         hiWdata <= v;
         hiWrite <= wrt;
         hiRead  <= !wrt;
      end else begin
         fbAddr  <= a;
         fbWdata <= v;
         fbWrite <= wrt;
         fbRead  <= !wrt;
      end
      @(posedge clk_sys);
      {hiWrite, hiRead, fbWrite, fbRead} <= 4'h0;
      #1 q = h ? hiRdata : fbRdata;
   endtask
   task automatic wr(input bit h, input logic [11:0] a, input logic [7:0] v);
      regAcc(h, 1'b1, a, v);
      if (!h && a == `DCS_OFS_TDIFF_DEPTH) mTd = v[3:0];
      if (!h && a == `DCS_OFS_SPEED_DEPTH) mSp = v[3:0];
      if (!h && a == `DCS_OFS_OWNERSHIP) mOwn = v & 8'h31;
      if (a == `DCS_OFS_ACTIVATION && h == mOwn[0]) mAct = v;
   endtask
   function automatic logic [7:0] expRead(input logic [11:0] a);
      case (a)
         `DCS_OFS_TDIFF_DEPTH:  return 8'(mTd);
         `DCS_OFS_SPEED_DEPTH:  return 8'(mSp);
         `DCS_OFS_OWNERSHIP:    return 8'(mOwn) | (sysTimeHostCtrl ? 8'h10 : 8'h00);
         `DCS_OFS_ACTIVATION:   return 8'(mAct);
         `DCS_OFS_PULSE_LEN_LO: return 8'(mLen);
         `DCS_OFS_PULSE_LEN_HI: return 8'(mLen >> 8);
         default:               return 8'h00;
      endcase
   endfunction
   task automatic rdAll;
      for (int h = 0; h < 2; h++) begin
         foreach (regList[i]) begin
            regAcc(h[0], 1'b0, regList[i], 8'h00);
            check("read data", 16'(q), 16'(expRead(regList[i])));
         end
      end
   endtask
   task automatic cmpOut;
      check("depths", {8'h00, timeDiffDepth, speedDepth}, 16'((mTd << 4) | mSp));
      check("owners", {13'h0, latch1Host, latch0Host, syncHostOwned},
         16'({mOwn[5], mOwn[4] | sysTimeHostCtrl, mOwn[0]}));
      check("act bits", {11'h0, nearFutureShort, plausCheckEn, startTimeExtend, autoActivate,
         syncUnitActive}, 16'({mAct[6:3], mAct[0]}));
   endtask
   task automatic fire(input logic [4:0] m, input logic s);
      @(posedge clk_sys);
      evReq <= m;
      slow  <= s;
      @(posedge clk_sys);
      evReq <= 5'h00;
      #1;
   endtask
   task automatic load(input int l);
      @(posedge clk_sys);
      eepromPulseLen <= 16'(l);
      eepromLoad     <= 1'b1;
      @(posedge clk_sys);
      eepromLoad <= 1'b0;
      mLen = l;
   endtask
   // Waits for a pulse on one output, then counts its cycles
   task automatic pw(input bit b);
      int n;
      n = 0;
      w = 0;
      while ((b ? syncOutB : syncOutA) !== 1'b1 && n < 30) begin
         @(posedge clk_sys);
         #1 n++;
      end
      while ((b ? syncOutB : syncOutA) === 1'b1 && w < 300) begin
         @(posedge clk_sys);
         #1 w++;
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {rst_b, fbWrite, fbRead, hiWrite, hiRead, eepromLoad, sysTimeHostCtrl, slow} = 8'h00;
      {fbAddr, hiAddr, fbWdata, hiWdata, eepromPulseLen, evReq} = 61'h0;
      {n_mismatch, checks, mOwn, mAct, mLen, mTd, mSp} = {32'h0, 32'h0, 96'h0, 32'h4, 32'hC};
      seed = 21584;
      lens[1] = 1 + ($random(seed) & 63);
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdAll();
      cmpOut();
      repeat (3) begin
         d = 8'($random(seed));
         wr(0, `DCS_OFS_TDIFF_DEPTH, d);
         check("time diff clear", 16'(timeDiffReset), 16'h1);
         wr(0, `DCS_OFS_SPEED_DEPTH, ~d);
         check("speed clear", 16'(speedFilterReset), 16'h1);
         wr(1, `DCS_OFS_TDIFF_DEPTH, d ^ 8'h5A);
         check("host clear", 16'(timeDiffReset), 16'h0);
         wr(1, `DCS_OFS_OWNERSHIP, 8'hFF);
         cmpOut();
      end
      for (int o = 0; o < 2; o++) begin
         wr(0, `DCS_OFS_OWNERSHIP, o ? 8'hFF : 8'h00);
         fire(5'h18, 1'b0);
         @(posedge clk_sys);
         #1 check("latch irq", {12'h0, latchIrqHost, latchIrqFieldbus}, o ? 16'hC : 16'h3);
         wr(o == 0, `DCS_OFS_ACTIVATION, 8'h79);
         wr(o[0], `DCS_OFS_ACTIVATION, 8'($random(seed)) & 8'h79);
         rdAll();
         cmpOut();
      end
      sysTimeHostCtrl <= 1'b1;
      wr(0, `DCS_OFS_OWNERSHIP, 8'h00);
      rdAll();
      cmpOut();
      sysTimeHostCtrl <= 1'b0;
      foreach (lens[i]) begin
         load(lens[i]);
         wr(0, `DCS_OFS_PULSE_LEN_LO, 8'hFF);
         rdAll();
         wr(0, `DCS_OFS_ACTIVATION, 8'h07);
         if (lens[i] != 0) begin
            fire(5'h02, i[0]);
            pw(0);
            check("width A", 16'(w), 16'((mLen * 10 + 24) / 25));
            fire(5'h04, 1'b0);
            pw(1);
            check("width B", 16'(w), 16'((mLen * 10 + 24) / 25));
         end
      end
      wr(0, `DCS_OFS_ACTIVATION, 8'h01);
      fire(5'h06, 1'b0);
      pw(0);
      check("gen off", 16'(w), 16'h0);
      wr(0, `DCS_OFS_ACTIVATION, 8'h87);
      @(posedge clk_sys);
      #1 check("debug pulse", {14'h0, syncOutB, syncOutA}, 16'h3);
      regAcc(0, 0, `DCS_OFS_STATUS_A, 8'h00);
      check("fb status", {q, 7'h0, syncOutA}, 16'h0101);
      regAcc(1, 0, `DCS_OFS_STATUS_A, 8'h00);
      @(posedge clk_sys);
      #1 check("ack clear A", {q, 6'h0, syncOutB, syncOutA}, 16'h0102);
      regAcc(1, 0, `DCS_OFS_STATUS_B, 8'h00);
      @(posedge clk_sys);
      #1 check("ack clear B", {q, 6'h0, syncOutB, syncOutA}, 16'h0100);
      wr(0, `DCS_OFS_ACTIVATION, 8'h08);
      fire(5'h01, 1'b1);
      repeat (3) @(posedge clk_sys);
      #1 mAct = 9;
      cmpOut();
      rdAll();
      end_sim();
   end
endmodule
